/* File: rtl/sdmbc_pkg.sv */
// Shared constants and types of the SDRAM mode and burst control block
package sdmbc_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam int COL_W  = 8;
   localparam int MEM_W  = 9;   // Bank bit above the column

   // ****************************************************************
   // Command codes on {ras_n, cas_n, we_n} with chip select low
   // ****************************************************************
   localparam logic [2:0] CMD_MRS   = 3'h0;
   localparam logic [2:0] CMD_REF   = 3'h1;
   localparam logic [2:0] CMD_PRE   = 3'h2;
   localparam logic [2:0] CMD_ACT   = 3'h3;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_READ  = 3'h5;
   localparam logic [2:0] CMD_BST   = 3'h6;

   // ****************************************************************
   // Operating code fields and address bit roles
   // ****************************************************************
   localparam int OP_WMODE_HI = 11;
   localparam int OP_WMODE_LO = 9;
   localparam int OP_LAT_HI   = 6;
   localparam int OP_LAT_LO   = 4;
   localparam int OP_ORDER    = 3;
   localparam int OP_LEN_HI   = 2;
   localparam int OP_LEN_LO   = 0;
   localparam int BANK_BIT    = 11;
   localparam int SCOPE_BIT   = 10;
   localparam int COL_HI      = 7;

   // ****************************************************************
   // Field codes and reset value
   // ****************************************************************
   localparam logic [2:0]  LAT_CODE_2    = 3'h2;
   localparam logic [2:0]  LAT_CODE_3    = 3'h3;
   localparam logic [2:0]  LEN_CODE_1    = 3'h0;
   localparam logic [2:0]  LEN_CODE_2    = 3'h1;
   localparam logic [2:0]  LEN_CODE_4    = 3'h2;
   localparam logic [2:0]  LEN_CODE_8    = 3'h3;
   localparam logic [2:0]  LEN_CODE_FULL = 3'h7;
   localparam logic [2:0]  WMODE_SINGLE  = 3'h1;
   localparam logic [11:0] MODE_RESET    = 12'h020;

   // Cycles from a read command to output enable (latency minus one)
   localparam logic [1:0] RD_WAIT_LAT2 = 2'h1;
   localparam logic [1:0] RD_WAIT_LAT3 = 2'h2;

   typedef enum logic [2:0] {
      RD_IDLE = 3'b001,
      RD_WAIT = 3'b010,
      RD_DATA = 3'b100
   } sdmbc_rd_state_e;

endpackage

/* File: rtl/sdmbc_mode_if.sv */
// Decoded operating mode passed between the block's modules
`timescale 1ns/10ps
interface sdmbc_mode_if;
   logic [7:0] burst_mask;    // Burst length minus one
   logic       interleave;
   logic       full_page;
   logic       single_write;
   logic       lat3;
   modport dec (output burst_mask, output interleave, output full_page,
                output single_write, output lat3);
   modport sink (input burst_mask, input interleave, input full_page,
                 input single_write, input lat3);
endinterface

/* File: rtl/sdmbc_mode_dec.sv */
// Decoder from the stored operating code to burst and latency settings
`timescale 1ns/10ps
module sdmbc_mode_dec
   import sdmbc_pkg::*;
(
   input  wire logic [11:0] op_i,
   sdmbc_mode_if.dec        mode
);

   // ****************************************************************
   // Field decode
   // ****************************************************************
   logic [2:0] len_code;
   assign len_code = op_i[OP_LEN_HI:OP_LEN_LO];

   // Reserved length codes fall back to a single beat
   always_comb
   begin
      mode.full_page  = 1'b0;
      mode.burst_mask = 8'h00;
      unique case (len_code)
         LEN_CODE_2:    mode.burst_mask = 8'h01;
         LEN_CODE_4:    mode.burst_mask = 8'h03;
         LEN_CODE_8:    mode.burst_mask = 8'h07;
         LEN_CODE_FULL:
         begin
            mode.full_page  = !op_i[OP_ORDER];
            mode.burst_mask = op_i[OP_ORDER] ? 8'h00 : 8'hff;
         end
         default:       mode.burst_mask = 8'h00;
      endcase
   end

   // Latency code 011 gives three; reserved codes also read as three
   assign mode.lat3         = (op_i[OP_LAT_HI:OP_LAT_LO] != LAT_CODE_2);
   assign mode.interleave   = op_i[OP_ORDER];
   assign mode.single_write =
      (op_i[OP_WMODE_HI:OP_WMODE_LO] == WMODE_SINGLE);

endmodule // sdmbc_mode_dec

/* File: rtl/sdmbc_col_gen.sv */
// Column address of one burst beat from start column and beat count
`timescale 1ns/10ps
module sdmbc_col_gen
   import sdmbc_pkg::*;
(
   sdmbc_mode_if.sink         mode,
   input  wire logic [7:0]    start_i,
   input  wire logic [7:0]    beat_i,
   output logic      [7:0]    col_o
);

   // ****************************************************************
   // Wrap inside the aligned block of burst size
   // ****************************************************************
   logic [7:0] seq_off;
   logic [7:0] int_off;

   assign seq_off = 8'(start_i + beat_i);
   assign int_off = start_i ^ beat_i;
   assign col_o   = (start_i & ~mode.burst_mask)
                  | ((mode.interleave ? int_off : seq_off) & mode.burst_mask);

endmodule // sdmbc_col_gen

/* File: rtl/sdmbc_core.sv */
// Top of the SDRAM mode register, bank select and burst data path
`timescale 1ns/10ps
module sdmbc_core
   import sdmbc_pkg::*;
(
   input  wire logic                          MCLK_I,
   input  wire logic                          RST_I,
   input  wire logic                          CKE_I,
   input  wire logic                          CS_N_I,
   input  wire logic                          RAS_N_I,
   input  wire logic                          CAS_N_I,
   input  wire logic                          WE_N_I,
   input  wire logic [sdmbc_pkg::ADDR_W-1:0]  ADDR_I,
   input  wire logic [1:0]                    BYTE_MASK_I,
   input  wire logic [sdmbc_pkg::DATA_W-1:0]  DQ_I,
   output logic      [sdmbc_pkg::DATA_W-1:0]  DQ_O,
   output logic      [1:0]                    DQ_OE_N_O,
   output logic      [1:0]                    BANK_OPEN_O
);

   // ****************************************************************
   // Command decode
   // ****************************************************************
   // The controller drives all pins from the same clock edge, so they
   // are read directly; a low clock gate simply masks the command.
   logic [2:0] cmd;
   logic       cmd_ok;
   logic       is_mrs;
   logic       is_act;
   logic       is_pre;
   logic       is_read;
   logic       is_write;
   logic       is_bst;
   logic       cmd_bank;
   logic       cmd_scope;
   logic [7:0] cmd_col;

   assign cmd       = {RAS_N_I, CAS_N_I, WE_N_I};
   assign cmd_ok    = CKE_I && !CS_N_I;
   assign is_mrs    = cmd_ok && (cmd == CMD_MRS);
   assign is_act    = cmd_ok && (cmd == CMD_ACT);
   assign is_pre    = cmd_ok && (cmd == CMD_PRE);
   assign is_read   = cmd_ok && (cmd == CMD_READ);
   assign is_write  = cmd_ok && (cmd == CMD_WRITE);
   assign is_bst    = cmd_ok && (cmd == CMD_BST);
   assign cmd_bank  = ADDR_I[BANK_BIT];
   assign cmd_scope = ADDR_I[SCOPE_BIT];
   assign cmd_col   = ADDR_I[COL_HI:0];

   // ****************************************************************
   // Operating mode word
   // ****************************************************************
   logic [11:0] mode_q;

   // Whole address bus becomes the operating code
   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
         mode_q <= MODE_RESET;
      else if (is_mrs)
         mode_q <= ADDR_I;
   end

   sdmbc_mode_if mode_bus ();

   sdmbc_mode_dec u_dec (
      .op_i (mode_q),
      .mode (mode_bus)
   );

   // ****************************************************************
   // Write burst engine
   // ****************************************************************
   logic       wr_run_q;
   logic       wr_bank_q;
   logic [7:0] wr_start_q;
   logic [7:0] wr_beat_q;
   logic       wr_ap_q;
   logic       wr_now;
   logic       wr_bank;
   logic [7:0] wr_start;
   logic [7:0] wr_beat;
   logic [7:0] wr_col;
   logic       wr_last;
   logic       wr_stop;
   logic       wr_ap_close;

   // Beat zero is taken in the command cycle itself
   assign wr_now   = is_write || (wr_run_q && !wr_stop);
   assign wr_bank  = is_write ? cmd_bank : wr_bank_q;
   assign wr_start = is_write ? cmd_col : wr_start_q;
   assign wr_beat  = is_write ? 8'h00 : wr_beat_q;
   // Precharge to the same bank cuts the burst with no further word
   assign wr_stop  = is_read || is_bst
                  || (is_pre && (cmd_scope || cmd_bank == wr_bank_q));
   assign wr_last  = mode_bus.single_write
                  || (!mode_bus.full_page && wr_beat == mode_bus.burst_mask);
   assign wr_ap_close = wr_now && wr_last
                     && (is_write ? cmd_scope : wr_ap_q)
                     && !mode_bus.full_page;

   sdmbc_col_gen u_wr_col (
      .mode    (mode_bus),
      .start_i (wr_start),
      .beat_i  (wr_beat),
      .col_o   (wr_col)
   );

   // Burst length paces the write and full page runs until stopped, except in single-write mode, which takes one word
   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         wr_run_q   <= 1'b0;
         wr_bank_q  <= 1'b0;
         wr_start_q <= 8'h00;
         wr_beat_q  <= 8'h00;
         wr_ap_q    <= 1'b0;
      end
      else
      begin
         if (is_write)
         begin
            wr_bank_q  <= cmd_bank;
            wr_start_q <= cmd_col;
            wr_ap_q    <= cmd_scope;
         end
         if (wr_now)
         begin
            wr_beat_q <= 8'(wr_beat + 8'h01);
            wr_run_q  <= !wr_last;
         end
         else if (wr_stop)
            wr_run_q  <= 1'b0;
      end
   end

   // ****************************************************************
   // Storage
   // ****************************************************************
   // Only bank and column index the array: rows share storage, which
   // keeps the model small while keeping burst ordering observable.
   logic [15:0] mem_q [0:(1 << MEM_W) - 1];

   // Masked lanes keep their old contents
   always_ff @(posedge MCLK_I)
   begin
      if (wr_now)
      begin
         if (!BYTE_MASK_I[0])
            mem_q[{wr_bank, wr_col}][7:0]  <= DQ_I[7:0];
         if (!BYTE_MASK_I[1])
            mem_q[{wr_bank, wr_col}][15:8] <= DQ_I[15:8];
      end
   end

   // ****************************************************************
   // Read burst engine
   // ****************************************************************
   sdmbc_rd_state_e rd_state_q;
   logic [1:0]      rd_dly_q;
   logic            rd_bank_q;
   logic [7:0]      rd_start_q;
   logic [7:0]      rd_beat_q;
   logic            rd_ap_q;
   logic [7:0]      rd_col;
   logic            rd_last;
   logic            rd_ap_close;

   assign rd_last = !mode_bus.full_page && (rd_beat_q == mode_bus.burst_mask);
   assign rd_ap_close = (rd_state_q == RD_DATA) && rd_last && rd_ap_q
                     && !is_read && !is_write && !is_bst;

   sdmbc_col_gen u_rd_col (
      .mode    (mode_bus),
      .start_i (rd_start_q),
      .beat_i  (rd_beat_q),
      .col_o   (rd_col)
   );

   // A new read replaces the running one; write or stop ends it
   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         rd_state_q <= RD_IDLE;
         rd_dly_q   <= 2'h0;
         rd_bank_q  <= 1'b0;
         rd_start_q <= 8'h00;
         rd_beat_q  <= 8'h00;
         rd_ap_q    <= 1'b0;
      end
      else if (is_read)
      begin
         rd_state_q <= RD_WAIT;
         rd_dly_q   <= mode_bus.lat3 ? RD_WAIT_LAT3 : RD_WAIT_LAT2;
         rd_bank_q  <= cmd_bank;
         rd_start_q <= cmd_col;
         rd_beat_q  <= 8'h00;
         rd_ap_q    <= cmd_scope;
      end
      else if (is_write || is_bst)
         rd_state_q <= RD_IDLE;
      else
      begin
         unique case (rd_state_q)
            RD_IDLE: rd_state_q <= RD_IDLE;
            RD_WAIT:
            begin
               rd_dly_q <= 2'(rd_dly_q - 2'h1);
               if (rd_dly_q == 2'h1)
                  rd_state_q <= RD_DATA;
            end
            RD_DATA:
            begin
               rd_beat_q <= 8'(rd_beat_q + 8'h01);
               if (rd_last)
                  rd_state_q <= RD_IDLE;
            end
            default: rd_state_q <= RD_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Read byte mask pipeline
   // ****************************************************************
   // Two stages whatever the latency, so masks line up with words
   logic [1:0] rmask1_q;
   logic [1:0] rmask2_q;

   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         rmask1_q <= 2'h3;
         rmask2_q <= 2'h3;
      end
      else
      begin
         rmask1_q <= BYTE_MASK_I;
         rmask2_q <= rmask1_q;
      end
   end

   // ****************************************************************
   // Data outputs
   // ****************************************************************
   // Enables drop one clock before the first word so the bus turns
   // round before data; a masked lane floats for that word.
   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         DQ_O      <= 16'h0000;
         DQ_OE_N_O <= 2'h3;
      end
      else if (rd_state_q == RD_DATA && !is_write && !is_bst)
      begin
         DQ_O      <= mem_q[{rd_bank_q, rd_col}];
         DQ_OE_N_O <= rmask2_q;
      end
      else if (rd_state_q == RD_WAIT && rd_dly_q == 2'h1
               && !is_write && !is_bst && !is_read)
         DQ_OE_N_O <= 2'h0;
      else
         DQ_OE_N_O <= 2'h3;
   end

   // ****************************************************************
   // Bank state
   // ****************************************************************
   // Activate wins over a close in the same cycle
   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
         BANK_OPEN_O <= 2'h0;
      else
      begin
         for (int b = 0; b < 2; b++)
         begin
            if (is_act && cmd_bank == 1'(b))
               BANK_OPEN_O[b] <= 1'b1;
            else if (is_pre && (cmd_scope || cmd_bank == 1'(b)))
               BANK_OPEN_O[b] <= 1'b0;
            else if (wr_ap_close && wr_bank == 1'(b))
               BANK_OPEN_O[b] <= 1'b0;
            else if (rd_ap_close && rd_bank_q == 1'(b))
               BANK_OPEN_O[b] <= 1'b0;
         end
      end
   end

endmodule // sdmbc_core

/* File: test/sdmbc_ctrl.sv */
// Behavioural memory controller driving the command pins
`timescale 1ns/10ps
module sdmbc_ctrl
   import sdmbc_pkg::*;
(
   input  wire logic        clk_i,
   output logic             cke_o,
   output logic             cs_n_o,
   output logic [2:0]       cmd_o,
   output logic [11:0]      addr_o,
   output logic [1:0]       mask_o,
   output logic [15:0]      dq_o
);
   // ****
   // Command tasks, all launched on the falling edge
   // ****
   initial
   begin
      {cke_o, cs_n_o, cmd_o, addr_o, mask_o, dq_o} = {5'h1f, 12'h0, 2'h3, 16'h0};
   end

   // One command, taken at the next rising edge; gate is {clock gate, select}
   task automatic cmd(input logic [2:0] c, input logic [11:0] a = 12'h0,
                      input logic [15:0] d = 16'h0, input logic [1:0] gate = 2'h2);
      @(negedge clk_i);
      {cke_o, cs_n_o, cmd_o, addr_o, dq_o} = {gate, c, a, d};
   endtask

   // Idle cycles; released data toggles so stale words never look valid
   task automatic nop(input int n);
      repeat (n)
      begin
         @(negedge clk_i);
         {cke_o, cs_n_o, cmd_o, dq_o} = {2'h2, 3'h7, ~dq_o};
      end
   endtask

   // Power-on hold, then precharge, mode set and refreshes
   task automatic init(input int hold);
      {cke_o, mask_o} = 3'h7;
      repeat (hold) @(negedge clk_i);
      mask_o = 2'h0;
      cmd(CMD_PRE, 12'h400);
      cmd(CMD_MRS, MODE_RESET);
      nop(2);
      cmd(CMD_REF);
      cmd(CMD_REF);
      nop(1);
   endtask
endmodule // sdmbc_ctrl

/* File: test/sdmbc_core_chk.sv */
// Port assertions for the SDRAM mode and burst control block
`timescale 1ns/10ps
module sdmbc_core_chk
   import sdmbc_pkg::*;
(
   input wire logic                         MCLK_I,
   input wire logic                         RST_I,
   input wire logic                         CKE_I,
   input wire logic                         CS_N_I,
   input wire logic                         RAS_N_I,
   input wire logic                         CAS_N_I,
   input wire logic                         WE_N_I,
   input wire logic [sdmbc_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [1:0]                   BYTE_MASK_I,
   input wire logic [sdmbc_pkg::DATA_W-1:0] DQ_I,
   input wire logic [sdmbc_pkg::DATA_W-1:0] DQ_O,
   input wire logic [1:0]                   DQ_OE_N_O,
   input wire logic [1:0]                   BANK_OPEN_O
);
   // ****
   // Command decode and shadow of the mode word
   // ****
   logic [11:0] mode_q;
   logic        bank_q;
   logic [2:0]  code;
   logic        take, rd_c, mask0, quiet, lat3;

   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RST_I);

   // Decoded command strobes
   assign take  = CKE_I && !CS_N_I;
   assign code  = {RAS_N_I, CAS_N_I, WE_N_I};
   assign rd_c  = take && code == CMD_READ;
   assign mask0 = BYTE_MASK_I == 2'h0;
   assign quiet = (!take || code == 3'h7) && mask0;
   assign lat3  = mode_q[6:4] != LAT_CODE_2;

   // Shadow mode so timing checks follow the programmed latency
   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
         {mode_q, bank_q} <= {MODE_RESET, 1'b0};
      else
         {mode_q, bank_q} <= {(take && code == CMD_MRS) ? ADDR_I : mode_q, ADDR_I[11]};
   end

   // ****
   // Assertions
   // ****
   a_act_opens: assert property (
      take && code == CMD_ACT |=> BANK_OPEN_O[bank_q]) else $error("bank not opened");
   a_pre_one: assert property (
      take && code == CMD_PRE && !ADDR_I[10] |=> !BANK_OPEN_O[bank_q]) else $error("bank kept");
   a_pre_all: assert property (
      take && code == CMD_PRE && ADDR_I[10] |=> BANK_OPEN_O == 2'h0) else $error("banks kept");
   a_auto_pre: assert property (
      take && code == CMD_WRITE && ADDR_I[10] && mode_q[2:0] == LEN_CODE_1
      |=> !BANK_OPEN_O[bank_q]) else $error("no auto precharge");
   a_oe_lat2: assert property (
      rd_c && !lat3 && mask0 && $past(BYTE_MASK_I) == 2'h0 ##1 quiet
      |=> DQ_OE_N_O == 2'h0) else $error("output enable late");
   a_oe_lat3: assert property (
      rd_c && lat3 && mask0 && DQ_OE_N_O == 2'h3 ##1 quiet [*2]
      |-> DQ_OE_N_O == 2'h3 ##1 DQ_OE_N_O == 2'h0) else $error("latency three enable");
   a_burst_four: assert property (
      rd_c && !lat3 && mode_q[2:0] == LEN_CODE_4 && mask0 ##1 quiet [*5]
      |=> DQ_OE_N_O == 2'h0 ##1 DQ_OE_N_O == 2'h3) else $error("burst of four length");
   a_full_runs: assert property (
      rd_c && !lat3 && mode_q[3:0] == {1'b0, LEN_CODE_FULL} && mask0 ##1 quiet [*8]
      |=> DQ_OE_N_O == 2'h0) else $error("full page stopped");
   a_read_mask: assert property (
      BYTE_MASK_I == 2'h1 ##3 !DQ_OE_N_O[1] |-> DQ_OE_N_O[0]) else $error("mask delay");
   a_stop_float: assert property (
      take && code == CMD_BST |=> DQ_OE_N_O == 2'h3) else $error("stop left outputs on");
   a_gate_no_open: assert property (
      !take |=> (BANK_OPEN_O & ~$past(BANK_OPEN_O)) == 2'h0)
      else $error("masked command opened a bank");
endmodule // sdmbc_core_chk

bind sdmbc_core sdmbc_core_chk u_chk (.MCLK_I(MCLK_I), .RST_I(RST_I), .CKE_I(CKE_I),
   .CS_N_I(CS_N_I), .RAS_N_I(RAS_N_I), .CAS_N_I(CAS_N_I), .WE_N_I(WE_N_I),
   .ADDR_I(ADDR_I), .BYTE_MASK_I(BYTE_MASK_I), .DQ_I(DQ_I), .DQ_O(DQ_O),
   .DQ_OE_N_O(DQ_OE_N_O), .BANK_OPEN_O(BANK_OPEN_O));

/* File: test/tb_sdmbc_core.sv */
// Self-checking bench for the SDRAM mode and burst control block
`timescale 1ns/10ps
`define CHK(act, exp) \
   begin \
      samples_checked++; \
      if ((act) !== (exp)) \
      begin \
         error_cnt++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (act), (exp)); \
      end \
   end
module tb_sdmbc_core;
   import sdmbc_pkg::*;
   logic        mclk, rst, cke, cs_n;
   logic [2:0]  cmd;
   logic [11:0] addr;
   logic [1:0]  mask, oe_n, bank_open;
   logic [15:0] dq_wr, dq_rd;
   int          error_cnt, samples_checked, cyc;

   // ****
   // Clock, watchdog and instances
   // ****
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Watchdog; the power-on hold dominates the run
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         finish_test();
      end
   end

   sdmbc_ctrl ctl (.clk_i(mclk), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd), .addr_o(addr),
                   .mask_o(mask), .dq_o(dq_wr));
   sdmbc_core dut (.MCLK_I(mclk), .RST_I(rst), .CKE_I(cke), .CS_N_I(cs_n),
                   .RAS_N_I(cmd[2]), .CAS_N_I(cmd[1]), .WE_N_I(cmd[0]), .ADDR_I(addr),
                   .BYTE_MASK_I(mask), .DQ_I(dq_wr), .DQ_O(dq_rd), .DQ_OE_N_O(oe_n),
                   .BANK_OPEN_O(bank_open));

   // ****
   // Shared tasks
   // ****
   task automatic finish_test();
      if (error_cnt == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Mode change needs idle banks and two quiet cycles; bank 0 reopened
   task automatic mode(input logic [11:0] op);
      ctl.cmd(CMD_PRE, 12'h400);
      ctl.cmd(CMD_MRS, op);
      ctl.nop(2);
      ctl.cmd(CMD_ACT, 12'h000);
   endtask

   // Burst write, then one clock of recovery
   task automatic wr(input logic [11:0] a, input logic [15:0] d[$], input bit fp);
      ctl.cmd(CMD_WRITE, a, d[0]);
      for (int i = 1; i < d.size(); i++)
         ctl.cmd(3'h7, 12'h0, d[i]);
      if (fp)
         ctl.cmd(CMD_BST);
      ctl.nop(1);
   endtask

   // Burst read; each word checked in its own cycle, then outputs float
   task automatic rd(input logic [11:0] a, input int cl, input logic [15:0] e[$],
                     input bit fp);
      ctl.cmd(CMD_READ, a);
      ctl.nop(cl);
      foreach (e[i])
      begin
         ctl.nop(1);
         `CHK(dq_rd, e[i])
      end
      if (fp)
         ctl.cmd(CMD_BST);
      ctl.nop(1);
      `CHK(oe_n, 2'h3)
   endtask

   // ****
   // Scenarios
   // ****
   // Both banks, column bits 9..8 ignored, wrap inside the block of four
   task automatic t_burst_seq();
      logic [15:0] d[$];
      logic [15:0] e[$];
      mode(12'h022);
      ctl.cmd(CMD_ACT, 12'h800);
      for (int i = 0; i < 4; i++)
      begin
         d.push_back(16'h1000 + 16'(i));
         e.push_back(16'h1000 + 16'((i + 3) % 4));
      end
      wr(12'hb02, d, 1'b0);
      foreach (d[i]) d[i] ^= 16'h0300;
      wr(12'h002, d, 1'b0);
      rd(12'h801, 2, e, 1'b0);
      foreach (e[i]) e[i] ^= 16'h0300;
      rd(12'h001, 2, e, 1'b0);
   endtask

   // Interleaved order at latency three, then single-word writes
   task automatic t_interleave();
      logic [15:0] d[$];
      logic [15:0] e[$];
      logic [15:0] s[$];
      mode(12'h03b);
      for (int i = 0; i < 8; i++)
      begin
         d.push_back(16'h4000 + 16'(i));
         e.push_back(16'h4000 + 16'(i ^ 5));
      end
      wr(12'h008, d, 1'b0);
      rd(12'h00d, 3, e, 1'b0);
      mode(12'h222);
      e = '{16'h5000, 16'h4001, 16'h4002, 16'h4003};
      s = '{16'h5000, 16'h5001, 16'h5002, 16'h5003};
      wr(12'h008, s, 1'b0);
      rd(12'h008, 2, e, 1'b0);
   endtask

   // Write mask acts at once, read mask two clocks later
   task automatic t_masks();
      mode(12'h022);
      wr(12'h004, '{16'ha0a0, 16'ha0a1, 16'ha0a2, 16'ha0a3}, 1'b0);
      ctl.cmd(CMD_WRITE, 12'h004, 16'hb0b0);
      ctl.cmd(3'h7, 12'h0, 16'hb0b1);
      ctl.mask_o = 2'h2;
      ctl.cmd(3'h7, 12'h0, 16'hb0b2);
      ctl.mask_o = 2'h0;
      ctl.cmd(3'h7, 12'h0, 16'hb0b3);
      ctl.nop(1);
      ctl.cmd(CMD_READ, 12'h004);
      ctl.nop(1);
      ctl.mask_o = 2'h1;
      ctl.nop(1);
      ctl.mask_o = 2'h0;
      ctl.nop(1);
      `CHK(dq_rd, 16'hb0b0)
      ctl.nop(1);
      `CHK(oe_n, 2'h1)
      `CHK(dq_rd[15:8], 8'ha0)
      ctl.nop(3);
   endtask

   // Full page wraps past column 255 until stopped
   task automatic t_full_page();
      logic [15:0] d[$];
      mode(12'h027);
      for (int i = 0; i < 12; i++)
         d.push_back(16'hc000 + 16'(i));
      wr(12'h0fe, d, 1'b1);
      rd(12'h0fe, 2, d, 1'b1);
   endtask

   // Deselect or a low clock gate masks the command
   task automatic t_gate();
      mode(12'h020);
      ctl.cmd(CMD_ACT, 12'h800, 16'h0, 2'h3);   // Deselected
      ctl.cmd(CMD_ACT, 12'h800, 16'h0, 2'h0);   // Clock gate low
      ctl.cmd(CMD_PRE, 12'h400, 16'h0, 2'h1);   // Both masked
      ctl.nop(1);
      `CHK(bank_open, 2'h1)
      ctl.cmd(CMD_ACT, 12'h800);
      ctl.nop(1);
      `CHK(bank_open, 2'h3)
   endtask

   // Reset in mid-burst floats outputs and restores the default mode
   task automatic t_reset();
      mode(12'h033);
      ctl.cmd(CMD_READ, 12'h008);
      ctl.nop(4);
      rst = 1'b1;
      ctl.nop(2);
      `CHK(oe_n, 2'h3)
      `CHK(bank_open, 2'h0)
      rst = 1'b0;
      ctl.cmd(CMD_ACT, 12'h000);
      rd(12'h009, 2, '{16'hc00b}, 1'b0);
   endtask

   // Bank select, precharge scope and auto-precharge
   task automatic t_banks();
      mode(12'h020);
      ctl.cmd(CMD_ACT, 12'h800);
      ctl.cmd(CMD_PRE, 12'h000);
      ctl.nop(1);
      `CHK(bank_open, 2'h2)
      ctl.cmd(CMD_ACT, 12'h000);
      ctl.cmd(CMD_WRITE, 12'hc05, 16'h0001);
      ctl.nop(1);
      `CHK(bank_open, 2'h1)
      ctl.cmd(CMD_WRITE, 12'h005, 16'h0002);
      ctl.nop(1);
      `CHK(bank_open, 2'h1)
      ctl.cmd(CMD_PRE, 12'h400);
      ctl.nop(1);
      `CHK(bank_open, 2'h0)
   endtask

   // Main sequence
   initial
   begin
      rst = 1'b1;
      repeat (20) @(negedge mclk);
      `CHK(oe_n, 2'h3)
      `CHK(bank_open, 2'h0)
      rst = 1'b0;
      ctl.init(12500);
      t_burst_seq();
      t_interleave();
      t_masks();
      t_full_page();
      t_gate();
      t_banks();
      t_reset();
      finish_test();
   end
endmodule // tb_sdmbc_core
